/* tsf_pkg.sv */
/*
 * tsf_pkg: register offsets, field positions, reset values and states for the
 * data slicer framing-match block.
 * assumes: a single 125 MHz system clock; byte addresses on a 32-bit AXI4-Lite bus.
 */
`default_nettype none
package tsf_pkg;
	// printed offsets are not all multiples of four: they are indices, byte address = 4*index
	localparam logic [7:0] IDX_IGNORE_HIGH = 8'hb8;
	localparam logic [7:0] IDX_IGNORE_MID = 8'hb9;
	localparam logic [7:0] IDX_IGNORE_LOW = 8'hba;
	localparam logic [7:0] IDX_PATTERN_HIGH = 8'hbb;
	localparam logic [7:0] IDX_PATTERN_MID = 8'hbc;
	localparam logic [7:0] IDX_PATTERN_LOW = 8'hbd;
	localparam logic [7:0] IDX_LINE_TYPE = 8'hc9;
	localparam logic [7:0] IDX_ERR_LIMITS = 8'hce;
	localparam logic [7:0] IDX_OUT_SETUP = 8'hcf;
	// status register of own choice, readable
	localparam logic [7:0] IDX_STATUS = 8'hd0;
	// reset values
	localparam logic [7:0] RST_IGNORE = 8'h00;
	localparam logic [7:0] RST_PATTERN_HIGH = 8'h27;
	localparam logic [7:0] RST_PATTERN_MID = 8'h55;
	localparam logic [7:0] RST_PATTERN_LOW = 8'h55;
	localparam logic [7:0] RST_LINE_TYPE = 8'h0d;
	localparam logic [7:0] RST_ERR_LIMITS = 8'h15;
	localparam logic [7:0] RST_OUT_SETUP = 8'h6b;
	// line_type_select fields
	localparam int LT_TEXT = 0;
	localparam int LT_NTSC = 1;
	localparam int LT_FULL = 2;
	localparam int LT_CC1 = 5;
	localparam int LT_CC2 = 6;
	localparam int LT_QUIT_OFF = 7;
	// bit_error_limits fields
	localparam int LIM_LOW = 0;
	localparam int LIM_MID = 2;
	localparam int LIM_HIGH = 4;
	// slicer_output_setup fields
	localparam int OS_COUNT = 0;
	localparam int OS_FILL = 6;
	localparam int OS_DUMP = 7;
	localparam logic [6:0] FILL_BYTES = 7'h40;
	localparam logic [7:0] CC_LINE = 8'h15;
	typedef enum logic [1:0] {TSF_HUNT, TSF_SEND, TSF_FILL, TSF_WAIT} tsf_state_t;
endpackage
`default_nettype wire

/* tsf_top.sv */
/*
 * tsf_top: data slicer configuration registers, framing-code matcher and line byte
 * output sequencer, with an AXI4-Lite register slave.
 * assumes: sliced bits and bytes arrive synchronous to clk_sys_i; the line start
 * strobe precedes each line; one write and one read under way at a time.
 */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tsf_top #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// line context from the video timing
	input wire logic line_start_i,
	input wire logic field_two_i,
	input wire logic [7:0] line_num_i,
	input wire logic text_line_i,
	// sliced bit stream and bytes
	input wire logic bit_valid_i,
	input wire logic bit_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	// line byte output
	output logic [7:0] out_byte_o,
	output logic out_valid_o,
	output logic out_last_o,
	output logic framing_match_o,
	// slicer controls
	output logic text_enable_o,
	output logic ntsc_mode_o,
	output logic cc_slice_o,
	output logic hquit_enable_o
);
	// configuration registers
	logic [23:0] pattern_r;
	logic [23:0] ignore_r;
	logic [7:0] line_type_r;
	logic [7:0] limits_r;
	logic [7:0] out_setup_r;
	// bus state
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	// framing state
	logic [23:0] shift_r;
	logic [4:0] bits_seen_r;
	logic [6:0] byte_cnt_r;
	logic [6:0] line_len;
	logic match_now;
	logic line_ok;
	tsf_pkg::tsf_state_t state_r;

	// byte address to register index; misaligned addresses give no hit
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[9:2];
	endfunction

	function automatic logic in_limit(input logic [7:0] diff, input logic [1:0] lim);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			n = n + {3'h0, diff[i]};
		end
		in_limit = (n <= {2'h0, lim});
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] ix;
		ix = reg_index(a);
		mapped = ((ix >= tsf_pkg::IDX_IGNORE_HIGH) && (ix <= tsf_pkg::IDX_PATTERN_LOW))
			|| (ix == tsf_pkg::IDX_LINE_TYPE) || (ix == tsf_pkg::IDX_ERR_LIMITS)
			|| (ix == tsf_pkg::IDX_OUT_SETUP) || (ix == tsf_pkg::IDX_STATUS);
		mapped = mapped && (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0);
	endfunction

	// write channel capture: address and data taken in either order
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end
		else if (aw_held_r && w_held_r)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (aw_held_r && w_held_r)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_r) ? 2'h0 : 2'h2;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration writes; only the low byte lane carries data
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pattern_r <= {tsf_pkg::RST_PATTERN_HIGH, tsf_pkg::RST_PATTERN_MID,
				tsf_pkg::RST_PATTERN_LOW};
			ignore_r <= {3{tsf_pkg::RST_IGNORE}};
			line_type_r <= tsf_pkg::RST_LINE_TYPE;
			limits_r <= tsf_pkg::RST_ERR_LIMITS;
			out_setup_r <= tsf_pkg::RST_OUT_SETUP;
		end
		else if (aw_held_r && w_held_r && wstrb_r[0] && mapped(awaddr_r))
		begin
			if (reg_index(awaddr_r) == tsf_pkg::IDX_IGNORE_HIGH)
				ignore_r[23:16] <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_IGNORE_MID)
				ignore_r[15:8] <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_IGNORE_LOW)
				ignore_r[7:0] <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_PATTERN_HIGH)
				pattern_r[23:16] <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_PATTERN_MID)
				pattern_r[15:8] <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_PATTERN_LOW)
				pattern_r[7:0] <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_LINE_TYPE)
				line_type_r <= wdata_r[7:0];
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_ERR_LIMITS)
				limits_r <= {2'h0, wdata_r[5:0]}; // reserved bits kept zero
			else if (reg_index(awaddr_r) == tsf_pkg::IDX_OUT_SETUP)
				out_setup_r <= wdata_r[7:0];
		end
	end

	// reads: configuration is write-only and reads zero; status shows the matcher
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
				if (reg_index(s_axi_araddr) == tsf_pkg::IDX_STATUS && mapped(s_axi_araddr))
					s_axi_rdata <= {22'h0, byte_cnt_r, framing_match_o, state_r};
				else
					s_axi_rdata <= 32'h0000_0000;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// line acceptance from the text line-type bit on text lines, or from the dump bit
	always_comb
	begin
		line_ok = out_setup_r[tsf_pkg::OS_DUMP]
			|| (text_line_i && line_type_r[tsf_pkg::LT_TEXT]);
		line_len = out_setup_r[tsf_pkg::OS_FILL] ? tsf_pkg::FILL_BYTES
			: {1'b0, out_setup_r[5:0]};
		// per-segment mismatch count against limit, masked bits excluded
		match_now = (bits_seen_r == 5'd24)
			&& in_limit((shift_r[7:0] ^ pattern_r[7:0]) & ~ignore_r[7:0],
				limits_r[tsf_pkg::LIM_LOW +: 2])
			&& in_limit((shift_r[15:8] ^ pattern_r[15:8]) & ~ignore_r[15:8],
				limits_r[tsf_pkg::LIM_MID +: 2])
			&& in_limit((shift_r[23:16] ^ pattern_r[23:16]) & ~ignore_r[23:16],
				limits_r[tsf_pkg::LIM_HIGH +: 2]);
	end

	// bit shifter: first received bit ends at the lsb after 24 bits
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || line_start_i)
		begin
			shift_r <= 24'h00_0000;
			bits_seen_r <= 5'd0;
		end
		else if (bit_valid_i && bits_seen_r != 5'd24 && state_r == tsf_pkg::TSF_HUNT)
		begin
			shift_r <= {bit_i, shift_r[23:1]};
			bits_seen_r <= bits_seen_r + 5'd1;
		end
	end

	// byte sequencer; the framing code counts toward the byte total, so three
	// bytes are already spent at match time
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_r <= tsf_pkg::TSF_WAIT;
			byte_cnt_r <= 7'd0;
			out_valid_o <= 1'b0;
			out_last_o <= 1'b0;
			out_byte_o <= 8'h00;
			framing_match_o <= 1'b0;
		end
		else
		begin
			out_valid_o <= 1'b0;
			out_last_o <= 1'b0;
			case (state_r)
				tsf_pkg::TSF_HUNT:
				begin
					if (match_now)
					begin
						framing_match_o <= 1'b1;
						byte_cnt_r <= 7'd3;
						state_r <= tsf_pkg::TSF_SEND;
					end
					else if (bits_seen_r == 5'd24 && out_setup_r[tsf_pkg::OS_DUMP])
					begin
						byte_cnt_r <= 7'd0;
						state_r <= tsf_pkg::TSF_SEND; // dump needs no match
					end
				end
				tsf_pkg::TSF_SEND:
				begin
					if (byte_cnt_r >= line_len)
						state_r <= tsf_pkg::TSF_WAIT;
					else if (byte_valid_i)
					begin
						out_byte_o <= byte_i;
						out_valid_o <= 1'b1;
						out_last_o <= (byte_cnt_r + 7'd1 == line_len);
						byte_cnt_r <= byte_cnt_r + 7'd1;
						if (byte_cnt_r + 7'd1 == {1'b0, out_setup_r[5:0]}
							&& out_setup_r[tsf_pkg::OS_FILL])
							state_r <= tsf_pkg::TSF_FILL;
					end
				end
				tsf_pkg::TSF_FILL:
				begin
					// pad with zero bytes up to sixty-four
					if (byte_cnt_r >= tsf_pkg::FILL_BYTES)
						state_r <= tsf_pkg::TSF_WAIT;
					else
					begin
						out_byte_o <= 8'h00;
						out_valid_o <= 1'b1;
						out_last_o <= (byte_cnt_r + 7'd1 == tsf_pkg::FILL_BYTES);
						byte_cnt_r <= byte_cnt_r + 7'd1;
					end
				end
				default:
				begin
					byte_cnt_r <= 7'd0;
				end
			endcase
			if (line_start_i)
			begin
				framing_match_o <= 1'b0;
				byte_cnt_r <= 7'd0;
				state_r <= line_ok ? tsf_pkg::TSF_HUNT : tsf_pkg::TSF_WAIT;
			end
		end
	end

	// slicer controls
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			text_enable_o <= 1'b0;
			ntsc_mode_o <= 1'b0;
			cc_slice_o <= 1'b0;
			hquit_enable_o <= 1'b0;
		end
		else
		begin
			text_enable_o <= line_type_r[tsf_pkg::LT_TEXT];
			ntsc_mode_o <= line_type_r[tsf_pkg::LT_NTSC];
			cc_slice_o <= (line_num_i == tsf_pkg::CC_LINE)
				&& ((!field_two_i && line_type_r[tsf_pkg::LT_CC1])
				|| (field_two_i && line_type_r[tsf_pkg::LT_CC2]));
			hquit_enable_o <= !line_type_r[tsf_pkg::LT_QUIT_OFF];
		end
	end
endmodule
`default_nettype wire

/* tsf_chk.sv */
/* tsf_chk: bus and line output assertions for tsf_top.
   assumes: bound to tsf_top, one clock, sync reset */
`timescale 1ns/1ps
`default_nettype none
module tsf_chk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// line side
	input wire logic line_start_i,
	input wire logic [7:0] line_num_i,
	input wire logic out_valid_o,
	input wire logic out_last_o,
	input wire logic framing_match_o,
	input wire logic cc_slice_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
			!s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response off time");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read response dropped");
	property p_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	property p_last;
		out_last_o |-> out_valid_o;
	endproperty
	a_last: assert property (p_last) else $error("last without byte");
	property p_hold;
		framing_match_o && !line_start_i |=> framing_match_o;
	endproperty
	a_hold: assert property (p_hold) else $error("match lost in line");
	property p_clear;
		line_start_i |=> !framing_match_o;
	endproperty
	a_clear: assert property (p_clear) else $error("match kept over line");
	property p_cc;
		cc_slice_o |-> $past(line_num_i) == 8'h15;
	endproperty
	a_cc: assert property (p_cc) else $error("caption on wrong line");
endmodule
bind tsf_top tsf_chk u_tsf_chk (.clk_sys_i, .rst_i, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .line_start_i, .line_num_i,
	.out_valid_o, .out_last_o, .framing_match_o, .cc_slice_o);
`default_nettype wire

/* tsf_feeder.sv */
/* tsf_feeder: front-end model, sends line start, 24 framing bits, then bytes.
   assumes: go_i held two edges by the bench */
`timescale 1ns/1ps
`default_nettype none
module tsf_feeder (
	// control from bench
	input wire logic clk_sys_i,
	input wire logic go_i,
	input wire logic [23:0] pat_i,
	input wire logic [7:0] seed_i,
	input wire logic [6:0] nbytes_i,
	// sliced stream
	output logic line_start_o,
	output logic bit_valid_o,
	output logic bit_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o,
	output logic busy_o
);
	int k;
	initial
	begin
		{line_start_o, bit_valid_o, bit_o, byte_valid_o, busy_o} = '0;
		byte_o = 8'h00;
		forever
		begin
			@(posedge clk_sys_i);
			if (go_i)
			begin
				busy_o <= 1'b1;
				line_start_o <= 1'b1;
				@(posedge clk_sys_i);
				line_start_o <= 1'b0;
				for (k = 0; k < 24; k++)
				begin
					bit_valid_o <= 1'b1;
					bit_o <= pat_i[k];
					@(posedge clk_sys_i);
				end
				// idle line shows the inverse, not a stale bit
				bit_valid_o <= 1'b0;
				bit_o <= ~pat_i[23];
				repeat (4) @(posedge clk_sys_i);
				for (k = 0; k < nbytes_i; k++)
				begin
					byte_valid_o <= 1'b1;
					byte_o <= seed_i + 8'(k);
					@(posedge clk_sys_i);
					byte_valid_o <= 1'b0;
					byte_o <= ~byte_o;
					repeat (2) @(posedge clk_sys_i);
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* text_slicer_framing_match_bench.sv */
/* bench for tsf_top: bus master tasks, expected byte queue and monitor.
   assumes: tsf_feeder drives the sliced stream */
`timescale 1ns/1ps
`default_nettype none
module text_slicer_framing_match_bench;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, go = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, field_two_i = 1'b0, text_line_i = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] line_num_i = '0, seed = '0, out_byte_o, byte_i;
	logic [6:0] nb = '0;
	logic [23:0] pat = '0;
	logic line_start_i, bit_valid_i, bit_i, byte_valid_i, out_valid_o, out_last_o;
	logic framing_match_o, text_enable_o, ntsc_mode_o, cc_slice_o, hquit_enable_o;
	int fail_count = 0, comparisons = 0;
	logic [7:0] expq[$];
	always #4 clk_sys_i = ~clk_sys_i;
	tsf_top u_tsf_top (.clk_sys_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_start_i, .field_two_i, .line_num_i,
		.text_line_i, .bit_valid_i, .bit_i, .byte_valid_i, .byte_i, .out_byte_o, .out_valid_o,
		.out_last_o, .framing_match_o, .text_enable_o, .ntsc_mode_o, .cc_slice_o,
		.hquit_enable_o);
	tsf_feeder u_tsf_feeder (.clk_sys_i, .go_i(go), .pat_i(pat), .seed_i(seed),
		.nbytes_i(nb), .line_start_o(line_start_i), .bit_valid_o(bit_valid_i), .bit_o(bit_i),
		.byte_valid_o(byte_valid_i), .byte_o(byte_i), .busy_o(busy));
	task automatic test_done;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge clk_sys_i);
		n++;
		if (n > 700)
		begin
			fail_count++;
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		int n;
		n = 0;
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			// late ready makes the slave hold its answer
			if (n == 3)
				s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(resp), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] idx, input logic [1:0] resp, input logic [31:0] edata);
		int n;
		n = 0;
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (n == 3)
				s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		chk("rresp", 32'(resp), 32'(s_axi_rresp));
		if (resp == 2'h0)
			chk("rdata", edata, s_axi_rdata);
	endtask
	task automatic line(input logic [23:0] p, input int nexp, input int npad, input logic mexp);
		logic [7:0] s;
		int n;
		s = 8'($urandom);
		for (n = 0; n < nexp; n++)
			expq.push_back(s + 8'(n));
		repeat (npad) expq.push_back(8'h00);
		pat <= p;
		seed <= s;
		nb <= (nexp > 0) ? 7'(nexp) : 7'h04;
		go <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		go <= 1'b0;
		n = 0;
		while (busy || expq.size() > 0)
			tick(n);
		repeat (4) @(posedge clk_sys_i);
		// the match flag stands until the next line start
		chk("match", 32'(mexp), 32'(framing_match_o));
	endtask
	// every forwarded byte must match the oldest expected one
	always @(posedge clk_sys_i)
		if (out_valid_o === 1'b1)
		begin
			if (expq.size() == 0)
				chk("spare byte", 32'h0, 32'h1);
			else
			begin
				chk("last", 32'(expq.size() == 1), 32'(out_last_o));
				chk("byte", 32'(expq.pop_front()), 32'(out_byte_o));
			end
		end
	initial
	begin
		int n;
		int m;
		void'($urandom(32153));
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("hquit", 32'h1, 32'(hquit_enable_o));
		chk("text", 32'h1, 32'(text_enable_o));
		chk("ntsc", 32'h0, 32'(ntsc_mode_o));
		rd(tsf_pkg::IDX_OUT_SETUP, 2'h0, 32'h0);
		rd(8'h10, 2'h2, 32'h0);
		wr(8'h10, 8'hff, 2'h2);
		line(24'h275555, 40, 21, 1'b1);
		rd(tsf_pkg::IDX_STATUS, 2'h0, {22'h0, 7'h00, 1'b1, tsf_pkg::TSF_WAIT});
		wr(tsf_pkg::IDX_OUT_SETUP, 8'h08, 2'h0);
		line(24'h265454, 5, 0, 1'b1);
		line(24'h275556, 0, 0, 1'b0);
		wr(tsf_pkg::IDX_IGNORE_LOW, 8'h03, 2'h0);
		line(24'h275556, 5, 0, 1'b1);
		wr(tsf_pkg::IDX_ERR_LIMITS, 8'h00, 2'h0);
		line(24'h275456, 0, 0, 1'b0);
		wr(tsf_pkg::IDX_PATTERN_HIGH, 8'ha6, 2'h0);
		line(24'ha65556, 5, 0, 1'b1);
		wr(tsf_pkg::IDX_ERR_LIMITS, 8'h20, 2'h0);
		line(24'ha55556, 5, 0, 1'b1);
		wr(tsf_pkg::IDX_OUT_SETUP, 8'h88, 2'h0);
		text_line_i <= 1'b0;
		line(24'h000000, 8, 0, 1'b0);
		wr(tsf_pkg::IDX_OUT_SETUP, 8'h08, 2'h0);
		line(24'ha65556, 0, 0, 1'b0);
		for (m = 0; m < 2; m++)
		begin
			wr(tsf_pkg::IDX_LINE_TYPE, m[0] ? 8'h23 : 8'hc0, 2'h0);
			for (n = 0; n < 4; n++)
			begin
				field_two_i <= n[0];
				line_num_i <= n[1] ? 8'h15 : 8'h14;
				repeat (3) @(posedge clk_sys_i);
				chk("cc", 32'(n[1] & (n[0] ^ m[0])), 32'(cc_slice_o));
			end
			chk("hquit", 32'(m[0]), 32'(hquit_enable_o));
			chk("text", 32'(m[0]), 32'(text_enable_o));
			chk("ntsc", 32'(m[0]), 32'(ntsc_mode_o));
		end
		test_done();
	end
endmodule
`default_nettype wire
